// *** sac_pkg.sv ***
package sac_pkg;

  // ****************************************************************
  // Channel and sequence sizing
  // ****************************************************************
  localparam int SAC_N_EXT = 16;
  localparam int SAC_N_INT = 2;
  localparam int SAC_N_CH = SAC_N_EXT + SAC_N_INT;
  localparam int SAC_CH_W = 5;
  localparam int SAC_SEQ_MAX = 16;
  localparam int SAC_LEN_W = 4;
  localparam int SAC_SLOT_W = 4;
  localparam logic [SAC_CH_W-1:0] SAC_CH_TEMP = 5'h10;
  localparam logic [SAC_CH_W-1:0] SAC_CH_VREF = 5'h11;

  // ****************************************************************
  // Data widths and encodings
  // ****************************************************************
  localparam int SAC_RAW_W = 12;
  localparam int SAC_DATA_W = 16;
  localparam int SAC_ACC_W = 20;
  localparam int SAC_CAL_W = 8;
  localparam logic [1:0] SAC_RES_12 = 2'h0;
  localparam logic [1:0] SAC_RES_10 = 2'h1;
  localparam logic [1:0] SAC_RES_8 = 2'h2;
  localparam logic [1:0] SAC_RES_6 = 2'h3;
  localparam int SAC_OVS_RATIO_W = 3;
  localparam int SAC_OVS_SHIFT_W = 4;
  localparam logic [SAC_OVS_SHIFT_W-1:0] SAC_OVS_SHIFT_MAX = 4'h8;
  localparam logic [SAC_CAL_W-1:0] SAC_CAL_RESET = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int SAC_CONV_CYC = 14;
  localparam int SAC_CAL_CYC = 64;
  localparam int SAC_CNT_W = 8;

  typedef enum logic [2:0]
  {
    SAC_ST_IDLE = 3'b000,
    SAC_ST_CAL = 3'b001,
    SAC_ST_CONV = 3'b010,
    SAC_ST_STORE = 3'b011,
    SAC_ST_NEXT = 3'b100
  } sac_state_t;

endpackage : sac_pkg

// *** sac_seq_mem.sv ***
`timescale 1ns/1ps
`default_nettype none

module sac_seq_mem
  import sac_pkg::*;
#(
  parameter int DEPTH = SAC_SEQ_MAX,
  parameter int AW = SAC_SLOT_W,
  parameter int DW = SAC_CH_W
)
(
  input wire logic clock_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);

  // ****************************************************************
  // Slot storage with registered read
  // ****************************************************************
  logic [DW-1:0] mem_r [DEPTH];

  always_ff @(posedge clock_i)
  begin
    if (we_i)
    begin
      mem_r[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clock_i)
  begin
    rdata_o <= mem_r[raddr_i];
  end

endmodule : sac_seq_mem

`default_nettype wire

// *** sac_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none

module sac_ctrl
  import sac_pkg::*;
#(
  parameter int CONV_CYC = SAC_CONV_CYC,
  parameter int CAL_CYC = SAC_CAL_CYC
)
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic conv_enable_i,
  input wire logic calib_start_set_i,
  input wire logic calib_reset_i,
  input wire logic continuous_sel_i,
  input wire logic [1:0] resolution_i,
  input wire logic align_msb_i,
  input wire logic ovs_en_i,
  input wire logic [SAC_OVS_RATIO_W-1:0] ovs_ratio_i,
  input wire logic [SAC_OVS_SHIFT_W-1:0] ovs_shift_i,
  input wire logic [SAC_LEN_W-1:0] seq_length_i,
  input wire logic seq_we_i,
  input wire logic [SAC_SLOT_W-1:0] seq_waddr_i,
  input wire logic [SAC_CH_W-1:0] seq_wdata_i,
  input wire logic sw_start_i,
  input wire logic trig_event_i,
  input wire logic eoc_clear_i,
  input wire logic end_of_conv_irq_en_i,
  input wire logic wd_irq_en_i,
  input wire logic wd_en_i,
  input wire logic [SAC_RAW_W-1:0] wd_high_i,
  input wire logic [SAC_RAW_W-1:0] wd_low_i,
  input wire logic [SAC_RAW_W-1:0] core_data_i,
  input wire logic [SAC_CAL_W-1:0] core_cal_i,
  output logic core_pd_o,
  output logic core_sample_o,
  output logic [SAC_CH_W-1:0] core_ch_o,
  output logic [SAC_CAL_W-1:0] core_cal_o,
  output logic calib_start_o,
  output logic busy_o,
  output logic [SAC_DATA_W-1:0] rdata_o,
  output logic eoc_o,
  output logic wd_flag_o,
  output logic irq_o
);

  // ****************************************************************
  // Input synchronisers for the trigger pin
  // ****************************************************************
  logic trig_s1_r;
  logic trig_s2_r;
  logic trig_d_r;
  logic trig_pulse;

  always_ff @(posedge clock_i)
  begin
    trig_s1_r <= trig_event_i;
    trig_s2_r <= trig_s1_r;
    trig_d_r <= trig_s2_r;
  end

  assign trig_pulse = trig_s2_r & ~trig_d_r;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [SAC_RAW_W-1:0] res_mask(input logic [1:0] res);
    logic [SAC_RAW_W-1:0] m;
    m = 12'hFFF;
    case (res)
      SAC_RES_10: m = 12'hFFC;
      SAC_RES_8: m = 12'hFF0;
      SAC_RES_6: m = 12'hFC0;
      default: m = 12'hFFF;
    endcase
    return m;
  endfunction : res_mask

  // ****************************************************************
  // Control state
  // ****************************************************************
  sac_state_t state_r;
  sac_state_t state_nxt;
  logic active;
  logic start_req;
  logic [SAC_CNT_W-1:0] cnt_r;
  logic [SAC_SLOT_W-1:0] slot_r;
  logic [SAC_CH_W-1:0] slot_ch;
  logic [SAC_CAL_W-1:0] cal_r;
  logic [SAC_ACC_W-1:0] acc_r;
  logic [8:0] ovs_cnt_r;
  logic [8:0] ovs_target;
  logic last_slot;
  logic [SAC_SLOT_W-1:0] slot_nxt;
  logic ovs_done;
  logic [SAC_RAW_W-1:0] sample;
  logic [SAC_ACC_W-1:0] acc_sum;
  logic [SAC_ACC_W-1:0] acc_shift;
  logic [SAC_DATA_W-1:0] aligned;
  logic wd_hit;

  assign active = rstn_i & conv_enable_i;
  assign start_req = (sw_start_i | trig_pulse) & ~calib_start_o;
  assign last_slot = (slot_r == seq_length_i);
  assign ovs_target = 9'h001 << ({1'b0, ovs_ratio_i} + 4'h1);
  assign ovs_done = ~ovs_en_i | (ovs_cnt_r == ovs_target - 9'h001);
  assign sample = core_data_i & res_mask(resolution_i);

  // Read ahead with the next slot so the channel is ready at sampling
  assign slot_nxt = (!active || state_r == SAC_ST_IDLE) ? '0 :
                    (state_r == SAC_ST_STORE && ovs_done) ?
                    (last_slot ? '0 : slot_r + 4'h1) : slot_r;

  sac_seq_mem u_seq_mem
  (
    .clock_i(clock_i),
    .we_i(seq_we_i),
    .waddr_i(seq_waddr_i),
    .wdata_i(seq_wdata_i),
    .raddr_i(slot_nxt),
    .rdata_o(slot_ch)
  );

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      SAC_ST_IDLE:
      begin
        if (calib_start_set_i)
        begin
          state_nxt = SAC_ST_CAL;
        end
        else if (start_req)
        begin
          state_nxt = SAC_ST_NEXT;
        end
      end
      SAC_ST_CAL:
      begin
        if (cnt_r == SAC_CNT_W'(CAL_CYC - 1))
        begin
          state_nxt = SAC_ST_IDLE;
        end
      end
      SAC_ST_NEXT: state_nxt = SAC_ST_CONV;
      SAC_ST_CONV:
      begin
        if (cnt_r == SAC_CNT_W'(CONV_CYC - 1))
        begin
          state_nxt = SAC_ST_STORE;
        end
      end
      SAC_ST_STORE:
      begin
        if (!ovs_done || !last_slot || continuous_sel_i)
        begin
          state_nxt = SAC_ST_NEXT;
        end
        else
        begin
          state_nxt = SAC_ST_IDLE;
        end
      end
      default: state_nxt = SAC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i)
  begin
    if (!active)
    begin
      state_r <= SAC_ST_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!active || state_r != state_nxt)
    begin
      cnt_r <= '0;
    end
    else
    begin
      cnt_r <= cnt_r + 8'h01;
    end
  end

  // ****************************************************************
  // Slot walk and oversample accumulation
  // ****************************************************************
  assign acc_sum = acc_r + {{(SAC_ACC_W-SAC_RAW_W){1'b0}}, sample};
  assign acc_shift = acc_sum >> ((ovs_shift_i > SAC_OVS_SHIFT_MAX) ?
                                 SAC_OVS_SHIFT_MAX : ovs_shift_i);

  always_comb
  begin
    aligned = ovs_en_i ? acc_shift[SAC_DATA_W-1:0] : {4'h0, sample};
    if (align_msb_i && !ovs_en_i)
    begin
      aligned = {sample, 4'h0};
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!active || state_r == SAC_ST_IDLE)
    begin
      slot_r <= '0;
      acc_r <= '0;
      ovs_cnt_r <= '0;
    end
    else if (state_r == SAC_ST_STORE)
    begin
      if (!ovs_done)
      begin
        acc_r <= acc_sum;
        ovs_cnt_r <= ovs_cnt_r + 9'h001;
      end
      else
      begin
        acc_r <= '0;
        ovs_cnt_r <= '0;
        slot_r <= last_slot ? '0 : slot_r + 4'h1;
      end
    end
  end

  // ****************************************************************
  // Calibration factor and start bit
  // ****************************************************************
  always_ff @(posedge clock_i)
  begin
    if (!active || calib_reset_i)
    begin
      cal_r <= SAC_CAL_RESET;
    end
    else if (state_r == SAC_ST_CAL && state_nxt == SAC_ST_IDLE)
    begin
      cal_r <= core_cal_i;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!active)
    begin
      calib_start_o <= 1'b0;
    end
    else
    begin
      calib_start_o <= (state_nxt == SAC_ST_CAL);
    end
  end

  // ****************************************************************
  // Results, flags and interrupt
  // ****************************************************************
  assign wd_hit = wd_en_i && state_r == SAC_ST_STORE &&
                  (core_data_i > wd_high_i || core_data_i < wd_low_i);

  always_ff @(posedge clock_i)
  begin
    if (!active)
    begin
      rdata_o <= '0;
      eoc_o <= 1'b0;
      wd_flag_o <= 1'b0;
    end
    else
    begin
      if (state_r == SAC_ST_STORE && ovs_done)
      begin
        rdata_o <= aligned;
      end
      if (state_r == SAC_ST_STORE && ovs_done && last_slot)
      begin
        eoc_o <= 1'b1;
      end
      else if (eoc_clear_i)
      begin
        eoc_o <= 1'b0;
      end
      if (wd_hit)
      begin
        wd_flag_o <= 1'b1;
      end
      else if (eoc_clear_i)
      begin
        wd_flag_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (!active)
    begin
      irq_o <= 1'b0;
    end
    else
    begin
      irq_o <= (eoc_o & end_of_conv_irq_en_i) | (wd_flag_o & wd_irq_en_i);
    end
  end

  // ****************************************************************
  // Analog core drive
  // ****************************************************************
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i)
    begin
      core_pd_o <= 1'b1;
      core_sample_o <= 1'b0;
      core_ch_o <= '0;
      core_cal_o <= SAC_CAL_RESET;
      busy_o <= 1'b0;
    end
    else
    begin
      core_pd_o <= ~conv_enable_i;
      core_sample_o <= active && state_nxt == SAC_ST_CONV && state_r == SAC_ST_NEXT;
      core_ch_o <= (slot_ch < SAC_CH_W'(SAC_N_CH)) ? slot_ch : SAC_CH_TEMP;
      core_cal_o <= cal_r;
      busy_o <= active && state_nxt != SAC_ST_IDLE;
    end
  end

endmodule : sac_ctrl

`default_nettype wire

// *** sac_ctrl_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module sac_ctrl_monitor
  import sac_pkg::*;
#(
  parameter int CONV_CYC = SAC_CONV_CYC,
  parameter int CAL_CYC = SAC_CAL_CYC
)
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic conv_enable_i,
  input wire logic calib_start_set_i,
  input wire logic sw_start_i,
  input wire logic eoc_clear_i,
  input wire logic end_of_conv_irq_en_i,
  input wire logic core_pd_o,
  input wire logic core_sample_o,
  input wire logic calib_start_o,
  input wire logic busy_o,
  input wire logic eoc_o,
  input wire logic irq_o
);
  // ****************************************
  // Calibration length counter and checks
  // ****************************************
  localparam int EOC_MAX = CONV_CYC + 4;
  logic [SAC_CNT_W-1:0] cal_cnt_r;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);
  always_ff @(posedge clock_i)
  begin
    if (!rstn_i || !calib_start_o)
      cal_cnt_r <= 8'h00;
    else
      cal_cnt_r <= cal_cnt_r + 8'h01;
  end
  sequence s_take;
    sw_start_i && conv_enable_i && !busy_o && !calib_start_o;
  endsequence
  sequence s_cal_take;
    calib_start_set_i && conv_enable_i && !busy_o && !calib_start_o;
  endsequence
  a_pd_tracks_en: assert property (1'b1 |=> core_pd_o == !$past(conv_enable_i))
    else $error("power-down does not follow enable");
  a_disable_holds: assert property (!conv_enable_i |=> !busy_o && !calib_start_o && !eoc_o)
    else $error("disabled block not idle");
  a_cal_begins: assert property (s_cal_take |=> calib_start_o)
    else $error("calibration did not start");
  a_cal_stays: assert property (calib_start_o |-> cal_cnt_r < CAL_CYC)
    else $error("calibration too long");
  a_cal_ends: assert property ($fell(calib_start_o) && $past(rstn_i) && $past(conv_enable_i)
    |-> cal_cnt_r == CAL_CYC)
    else $error("calibration length wrong");
  a_start_samples: assert property (s_take |-> ##2 core_sample_o)
    else $error("start not followed by sample");
  a_cal_no_sample: assert property (calib_start_o [*3] |-> !core_sample_o)
    else $error("sample during calibration");
  a_eoc_follows: assert property (s_take ##2 core_sample_o |-> ##[1:EOC_MAX] (eoc_o || core_sample_o))
    else $error("conversion did not finish");
  a_eoc_irq: assert property (eoc_o && end_of_conv_irq_en_i |-> ##[0:1] irq_o)
    else $error("missing end interrupt");
  a_eoc_clears: assert property (eoc_o && eoc_clear_i && !busy_o |=> !eoc_o)
    else $error("end flag not cleared");
endmodule : sac_ctrl_monitor
`default_nettype wire

// *** sac_core_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module sac_core_model
  import sac_pkg::*;
#(
  parameter logic [SAC_CAL_W-1:0] CAL_VAL = 8'h5C
)
(
  input wire logic clock_i,
  input wire logic pd_i,
  input wire logic sample_i,
  input wire logic [SAC_CH_W-1:0] ch_i,
  output logic [SAC_RAW_W-1:0] data_o,
  output logic [SAC_CAL_W-1:0] cal_o
);
  // ****************************************
  // Analog core stand-in
  // ****************************************
  initial data_o = 12'h5A5;
  initial cal_o = 8'hA5;
  always @(posedge clock_i)
  begin
    if (pd_i)
    begin
      data_o <= ~data_o;
      cal_o <= ~cal_o;
    end
    else
    begin
      cal_o <= CAL_VAL;
      if (sample_i)
        data_o <= {ch_i, 7'h2A};
    end
  end
endmodule : sac_core_model
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb;
  import sac_pkg::*;
  // ****************************************
  // Stimulus and checks
  // ****************************************
  localparam int CONV = 4;
  localparam int CAL = 4;
  localparam logic [7:0] CAL_VAL = 8'h5C;
  logic clock_i = 1'b0;
  logic rstn_i, conv_enable_i, calib_start_set_i, calib_reset_i, continuous_sel_i;
  logic align_msb_i, ovs_en_i, seq_we_i, sw_start_i, trig_event_i, eoc_clear_i;
  logic end_of_conv_irq_en_i, wd_irq_en_i, wd_en_i;
  logic [1:0] resolution_i;
  logic [2:0] ovs_ratio_i;
  logic [3:0] ovs_shift_i, seq_length_i, seq_waddr_i;
  logic [4:0] seq_wdata_i, core_ch_o;
  logic [11:0] wd_high_i, wd_low_i, core_data_i;
  logic [7:0] core_cal_i, core_cal_o;
  logic [15:0] rdata_o;
  logic core_pd_o, core_sample_o, calib_start_o, busy_o, eoc_o, wd_flag_o, irq_o;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  sac_ctrl #(.CONV_CYC(CONV), .CAL_CYC(CAL)) sac_ctrl_inst (.*);
  sac_core_model #(.CAL_VAL(CAL_VAL)) sac_core_model_inst (.clock_i(clock_i),
    .pd_i(core_pd_o), .sample_i(core_sample_o), .ch_i(core_ch_o),
    .data_o(core_data_i), .cal_o(core_cal_i));
  initial
  begin
    forever #12.5 clock_i = ~clock_i;
  end
  function automatic logic [15:0] ev(logic [4:0] ch, logic [1:0] res, logic msb);
    logic [11:0] v;
    v = {ch, 7'h2A} & (12'hFFF << (2 * res));
    return msb ? {v, 4'h0} : {4'h0, v};
  endfunction : ev
  task tally_and_finish;
    if (fail_count == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic put_slot(logic [3:0] a, logic [4:0] ch);
    seq_we_i <= 1'b1;
    seq_waddr_i <= a;
    seq_wdata_i <= ch;
    @(posedge clock_i);
    seq_we_i <= 1'b0;
    @(posedge clock_i);
  endtask : put_slot
  task automatic calibrate;
    int n;
    calib_start_set_i <= 1'b1;
    @(posedge clock_i);
    calib_start_set_i <= 1'b0;
    sw_start_i <= 1'b1;
    @(posedge clock_i);
    sw_start_i <= 1'b0;
    #1;
    `CHK(calib_start_o, 1'b1)
    n = 0;
    while (calib_start_o !== 1'b0 && n++ < 200)
    begin
      @(posedge clock_i);
      #1;
    end
    repeat (2) @(posedge clock_i);
    #1;
    `CHK(core_cal_o, CAL_VAL)
    `CHK(busy_o | eoc_o, 1'b0)
    @(posedge clock_i);
  endtask : calibrate
  task automatic wait_eoc(logic [15:0] expv, logic expirq);
    int n;
    n = 0;
    #1;
    while (eoc_o !== 1'b1 && n++ < 3000)
    begin
      @(posedge clock_i);
      #1;
    end
    `CHK(rdata_o, expv)
    @(posedge clock_i);
    eoc_clear_i <= 1'b1;
    @(posedge clock_i);
    eoc_clear_i <= 1'b0;
    #1;
    `CHK(irq_o, expirq)
    @(posedge clock_i);
    #1;
    `CHK(eoc_o, 1'b0)
    @(posedge clock_i);
  endtask : wait_eoc
  task automatic convert(logic trig, logic [15:0] expv, logic expirq);
    sw_start_i <= !trig;
    trig_event_i <= trig;
    @(posedge clock_i);
    sw_start_i <= 1'b0;
    trig_event_i <= 1'b0;
    wait_eoc(expv, expirq);
  endtask : convert
  initial
  begin
    {rstn_i, conv_enable_i, calib_start_set_i, calib_reset_i, continuous_sel_i} = '0;
    {align_msb_i, ovs_en_i, seq_we_i, sw_start_i, trig_event_i, eoc_clear_i} = '0;
    {end_of_conv_irq_en_i, wd_irq_en_i, wd_en_i, resolution_i, ovs_ratio_i} = '0;
    {ovs_shift_i, seq_length_i, seq_waddr_i, seq_wdata_i, wd_high_i, wd_low_i} = '0;
    repeat (3) @(posedge clock_i);
    rstn_i <= 1'b1;
    conv_enable_i <= 1'b1;
    repeat (14) @(posedge clock_i);
    calibrate();
    calib_reset_i <= 1'b1;
    @(posedge clock_i);
    calib_reset_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
    `CHK(core_cal_o, SAC_CAL_RESET)
    @(posedge clock_i);
    calibrate();
    for (int c = 0; c < SAC_N_CH; c++)
    begin
      put_slot(4'h0, 5'(c));
      convert(c[0], ev(5'(c), SAC_RES_12, 1'b0), 1'b0);
    end
    end_of_conv_irq_en_i <= 1'b1;
    for (int r = 0; r < 5; r++)
    begin
      resolution_i <= (r == 4) ? SAC_RES_12 : 2'(r);
      align_msb_i <= (r == 4);
      convert(1'b0, ev(5'h11, 2'(r % 4), r == 4), 1'b1);
    end
    {end_of_conv_irq_en_i, align_msb_i, ovs_en_i} <= 3'h1;
    for (int k = 0; k < 2; k++)
    begin
      ovs_ratio_i <= k ? 3'h7 : 3'h0;
      ovs_shift_i <= k ? 4'hF : 4'h1;
      convert(1'b1, ev(5'h11, SAC_RES_12, 1'b0), 1'b0);
    end
    ovs_en_i <= 1'b0;
    for (int i = 0; i < SAC_SEQ_MAX; i++)
      put_slot(4'(i), (i == 15) ? 5'h11 : 5'(i));
    seq_length_i <= 4'hF;
    convert(1'b0, ev(5'h11, SAC_RES_12, 1'b0), 1'b0);
    seq_length_i <= 4'h0;
    {wd_en_i, wd_irq_en_i} <= 2'h3;
    convert(1'b1, ev(5'h00, SAC_RES_12, 1'b0), 1'b1);
    {wd_en_i, wd_irq_en_i, continuous_sel_i} <= 3'h1;
    convert(1'b0, ev(5'h00, SAC_RES_12, 1'b0), 1'b0);
    wait_eoc(ev(5'h00, SAC_RES_12, 1'b0), 1'b0);
    continuous_sel_i <= 1'b0;
    conv_enable_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    sw_start_i <= 1'b1;
    @(posedge clock_i);
    sw_start_i <= 1'b0;
    repeat (20) @(posedge clock_i);
    #1;
    `CHK(busy_o | eoc_o | core_sample_o, 1'b0)
    `CHK(core_pd_o, 1'b1)
    tally_and_finish();
  end
endmodule : tb
bind sac_ctrl sac_ctrl_monitor #(.CONV_CYC(CONV_CYC), .CAL_CYC(CAL_CYC)) sac_ctrl_monitor_inst (.*);
`default_nettype wire
